// file: hdl/tc_regs.svh
// register offsets, field positions, reset values and timing counts of
// the timer/counter front end; assumes an 8-bit register bus, 11-bit address
//
// Behaviour
// - prescale field picks base tick: 00 /4, 01 /16, 10 /64, 11 reserved
// - one base tick feeds every timer in timer mode
// - base tick selection applies in timer mode and to timer zero's split-mode high byte, never to count pin edges
// - in counter mode each falling edge on the count pin steps the count by one
// - count pins sampled every two cycles; counting limited to osc/4
// - each timer selects timer or counter by its own bit; zero and one count upward
// - count registers readable at any time, returning the live count
// - timers zero and one have four modes; mode 0 is 16-bit auto-reload
// - mode 00 reload16, 01 free16, 10 reload8, 11 split (zero only)
// - mode 0 overflow sets flag unless output enabled, reloads both bytes from reload registers
// - overflow toggles an output; enable bit picks toggle or port latch
// - gate set: count only while irq pin high and run set
// - third 16-bit timer counts up or down
// - timers zero and one have reload low/high registers, reset zero
// - third timer has capture/reload low/high registers, reset zero
// - 8-bit accesses only; wide write stores low byte, upper read zero
`ifndef TC_REGS_SVH
`define TC_REGS_SVH

// register offsets
`define TC_A_RUN_CTRL 11'h410
`define TC_A_OUT_STAT 11'h411
`define TC_A_X_CTRL 11'h418
`define TC_A_X_MODE 11'h419
`define TC_A_SYS_CFG 11'h440
`define TC_A_ZERO_LO 11'h450
`define TC_A_ZERO_HI 11'h451
`define TC_A_ONE_LO 11'h452
`define TC_A_ONE_HI 11'h453
`define TC_A_ZERO_RLD_LO 11'h454
`define TC_A_ZERO_RLD_HI 11'h455
`define TC_A_ONE_RLD_LO 11'h456
`define TC_A_ONE_RLD_HI 11'h457
`define TC_A_X_LO 11'h458
`define TC_A_X_HI 11'h459
`define TC_A_X_CAP_LO 11'h45a
`define TC_A_X_CAP_HI 11'h45b
`define TC_A_MODE_SEL 11'h45c
`define TC_RESET_VAL 8'h00

// run/overflow control fields
`define TC_RF1 7
`define TC_RUN1 6
`define TC_RF0 5
`define TC_RUN0 4
// output enable status fields
`define TC_OE1 2
`define TC_OE0 0
`define TC_OSTAT_MASK 8'h05
// third timer control and mode fields
`define TC_XF 7
`define TC_XEXF 6
`define TC_XRCLK 5
`define TC_XTCLK 4
`define TC_XEXEN 3
`define TC_XRUN 2
`define TC_XCT 1
`define TC_XCPRL 0
`define TC_XMOD_MASK 8'h33
`define TC_XRCLK1 5
`define TC_XTCLK1 4
`define TC_XDCEN 0
// system configuration fields
`define TC_SCR_PT 3:2
`define TC_SCR_MASK 8'h0f
`define TC_PS_DIV4 2'b00
`define TC_PS_DIV16 2'b01
`define TC_PS_DIV64 2'b10
// mode select nibbles
`define TC_MZ_GATE 3
`define TC_MZ_CT 2
`define TC_MZ_OPM 1:0
`define TC_MO_GATE 7
`define TC_MO_CT 6
`define TC_MO_OPM 5:4

// timing
`define TC_CLK_NS 4
`define TC_OSC_NS 4
`define TC_SAMPLE_OSC 2
`define TC_SAMPLE_CYC ((`TC_SAMPLE_OSC * `TC_OSC_NS) / `TC_CLK_NS)

`endif

// file: hdl/tc_pkg.sv
// types of the timer/counter front end
// assumes the constants of tc_regs.svh
`default_nettype none
package tc_pkg;
	typedef enum logic [1:0] {
		OPM_RELOAD16 = 2'b00,
		OPM_FREE16 = 2'b01,
		OPM_RELOAD8 = 2'b10,
		OPM_SPLIT8 = 2'b11
	} op_mode_t;

	typedef struct packed {
		logic [5:0] div;
		logic tick;
		logic [7:0] timer_run_overflow_control;
		logic [7:0] timer_output_enable_status;
		logic [7:0] xctl;
		logic [7:0] xmod;
		logic [7:0] system_configuration;
		logic [7:0] timer_mode_select;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [7:0] timer_zero_reload_low;
		logic [7:0] timer_zero_reload_high;
		logic [7:0] timer_one_reload_low;
		logic [7:0] timer_one_reload_high;
		logic [7:0] tl2;
		logic [7:0] th2;
		logic [7:0] capl;
		logic [7:0] caph;
		logic tog0;
		logic tog1;
		logic pin0;
		logic pin1;
		logic [15:0] rdata;
	} tc_state_t;
endpackage
`default_nettype wire

// file: hdl/edge_sampler.sv
// samples the count pins at a fixed interval and flags falling edges
// assumes pins are synchronous to clk and held per the pin timing
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs.svh"
module edge_sampler #(
	parameter int N = 4,
	parameter int SAMPLE_CYC = `TC_SAMPLE_CYC
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// pins and results
	input wire logic [N-1:0] pins,
	output logic [N-1:0] level,
	output logic [N-1:0] fall
);
	typedef struct packed {
		logic [3:0] ph;
		logic [N-1:0] cur;
		logic [N-1:0] fall;
	} smp_t;

	localparam logic [3:0] PH_LAST = 4'(SAMPLE_CYC - 1);

	smp_t s;
	smp_t n;

	// take one sample per interval, edge from two successive samples
	always_comb
	begin
		n = s;
		n.fall = '0;
		if (s.ph == PH_LAST)
		begin
			n.ph = 4'h0;
			n.cur = pins;
			n.fall = s.cur & ~pins;
		end
		else
			n.ph = s.ph + 4'h1;
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk)
	begin
		if (reset)
			s <= '0;
		else if (ce)
			s <= n;
	end

	assign level = s.cur;
	assign fall = s.fall;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_sample_hold;
		ce && s.ph != PH_LAST |=> $stable(level);
	endproperty
	a_sample_hold: assert property (p_sample_hold) else $error("sample moved off interval");

	property p_fall_cause;
		ce && s.ph == PH_LAST |=> fall == ($past(level) & ~level);
	endproperty
	a_fall_cause: assert property (p_fall_cause) else $error("edge flag not from samples");

	c_fall: cover property (ce && fall[0]);
endmodule
`default_nettype wire

// file: hdl/timer_counter_front_end.sv
// three timer/counters with shared prescaler and 8-bit register port
// assumes an 8-bit register bus synchronous to clk; pins synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs.svh"
module timer_counter_front_end (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// register port
	input wire logic [10:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [15:0] sfr_wdata,
	output logic [15:0] sfr_rdata,
	// count and control pins
	input wire logic count_pin_zero,
	input wire logic count_pin_one,
	input wire logic count_pin_third,
	input wire logic third_ext_pin,
	input wire logic ext_irq_pin_zero,
	input wire logic ext_irq_pin_one,
	// port latch data for the shared pins
	input wire logic port_latch_zero,
	input wire logic port_latch_one,
	// outputs
	output logic timer_base_clock,
	output logic shared_pin_zero,
	output logic shared_pin_one
);
	import tc_pkg::*;

	tc_state_t s;
	tc_state_t n;
	logic [3:0] lvl;
	logic [3:0] fall;
	op_mode_t m0;
	op_mode_t m1;
	logic en0, en1, en_hi0, en2, ex2, down, capm, baud;
	logic ovf0, ovf1, ovf_hi0, ovf2;
	logic [16:0] st0;
	logic [16:0] st1;
	logic [15:0] cnt0, rld0, cnt2, cap2, nc2;
	logic [7:0] wd;

	// base tick due for the selected divide; reserved code never ticks
	function automatic logic base_due(logic [1:0] psel, logic [5:0] div);
		unique case (psel)
		`TC_PS_DIV4: return &div[1:0];
		`TC_PS_DIV16: return &div[3:0];
		`TC_PS_DIV64: return &div;
		default: return 1'b0;
		endcase
	endfunction

	// run bit qualified by the gate and irq pin
	function automatic logic gate_ok(logic gate, logic run, logic irq);
		return run & (~gate | irq);
	endfunction

	// one count step of timer zero or one: {overflow, high, low}
	function automatic logic [16:0] step(op_mode_t m, logic en,
		logic [7:0] th, logic [7:0] tl, logic [7:0] rh, logic [7:0] rl);
		logic [16:0] r;
		r = {1'b0, th, tl};
		if (en)
		begin
			unique case (m)
			OPM_RELOAD16: r = (r[15:0] == 16'hffff) ? {1'b1, rh, rl}
				: r + 17'h00001;
			OPM_FREE16: r = r + 17'h00001;
			OPM_RELOAD8: r = {tl == 8'hff, th,
				(tl == 8'hff) ? rl : tl + 8'h01};
			OPM_SPLIT8: r = {tl == 8'hff, th, tl + 8'h01};
			endcase
		end
		return r;
	endfunction

	// count pin sampling and edge detection
	edge_sampler #(
		.N(4),
		.SAMPLE_CYC(`TC_SAMPLE_CYC)
	) u_smp (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.pins({third_ext_pin, count_pin_third, count_pin_one, count_pin_zero}),
		.level(lvl),
		.fall(fall)
	);

	assign cnt0 = {s.th0, s.tl0};
	assign rld0 = {s.timer_zero_reload_high, s.timer_zero_reload_low};
	assign cnt2 = {s.th2, s.tl2};
	assign cap2 = {s.caph, s.capl};
	assign wd = sfr_wdata[7:0];

	// next state of the whole block
	always_comb
	begin
		n = s;
		// shared prescaler feeds every timer-mode timer
		n.div = s.div + 6'h01;
		n.tick = base_due(s.system_configuration[`TC_SCR_PT], s.div);
		m0 = op_mode_t'(s.timer_mode_select[`TC_MZ_OPM]);
		m1 = op_mode_t'(s.timer_mode_select[`TC_MO_OPM]);
		// count source: pin edge in counter mode, base tick otherwise
		en0 = gate_ok(s.timer_mode_select[`TC_MZ_GATE], s.timer_run_overflow_control[`TC_RUN0],
			ext_irq_pin_zero)
			& (s.timer_mode_select[`TC_MZ_CT] ? fall[0] : s.tick);
		en1 = gate_ok(s.timer_mode_select[`TC_MO_GATE], s.timer_run_overflow_control[`TC_RUN1],
			ext_irq_pin_one)
			& (s.timer_mode_select[`TC_MO_CT] ? fall[1] : s.tick)
			& (m1 != OPM_SPLIT8); // timer one holds in split mode
		en_hi0 = (m0 == OPM_SPLIT8) & s.timer_run_overflow_control[`TC_RUN1] & s.tick;
		// timers zero and one
		st0 = step(m0, en0, s.th0, s.tl0, s.timer_zero_reload_high, s.timer_zero_reload_low);
		st1 = step(m1, en1, s.th1, s.tl1, s.timer_one_reload_high, s.timer_one_reload_low);
		ovf0 = st0[16];
		ovf1 = st1[16];
		{n.th0, n.tl0} = st0[15:0];
		{n.th1, n.tl1} = st1[15:0];
		ovf_hi0 = en_hi0 & (s.th0 == 8'hff);
		if (en_hi0)
			n.th0 = s.th0 + 8'h01;
		// third timer: up/down reload, capture or baud
		baud = s.xctl[`TC_XRCLK] | s.xctl[`TC_XTCLK]
			| s.xmod[`TC_XRCLK1] | s.xmod[`TC_XTCLK1];
		capm = s.xctl[`TC_XCPRL] & ~baud;
		down = s.xmod[`TC_XDCEN] & ~capm & ~baud & ~lvl[3];
		en2 = s.xctl[`TC_XRUN] & (s.xctl[`TC_XCT] ? fall[2] : s.tick);
		ex2 = s.xctl[`TC_XEXEN] & fall[3] & (capm | ~s.xmod[`TC_XDCEN]);
		nc2 = cnt2;
		ovf2 = 1'b0;
		if (en2 && down)
		begin
			ovf2 = (cnt2 == cap2);
			nc2 = ovf2 ? 16'hffff : cnt2 - 16'h0001;
		end
		else if (en2)
		begin
			ovf2 = (cnt2 == 16'hffff);
			nc2 = ovf2 ? (capm ? 16'h0000 : cap2) : cnt2 + 16'h0001;
		end
		if (ex2 && capm)
			{n.caph, n.capl} = cnt2;
		else if (ex2)
			nc2 = cap2;
		{n.th2, n.tl2} = nc2;
		// overflow toggles
		if (ovf0)
			n.tog0 = ~s.tog0;
		if (ovf1)
			n.tog1 = ~s.tog1;
		// register writes take the low byte and win over counting
		if (sfr_wr)
		begin
			case (sfr_addr)
			`TC_A_RUN_CTRL: n.timer_run_overflow_control = wd;
			`TC_A_OUT_STAT: n.timer_output_enable_status = wd & `TC_OSTAT_MASK;
			`TC_A_X_CTRL: n.xctl = wd;
			`TC_A_X_MODE: n.xmod = wd & `TC_XMOD_MASK;
			`TC_A_SYS_CFG: n.system_configuration = wd & `TC_SCR_MASK;
			`TC_A_ZERO_LO: n.tl0 = wd;
			`TC_A_ZERO_HI: n.th0 = wd;
			`TC_A_ONE_LO: n.tl1 = wd;
			`TC_A_ONE_HI: n.th1 = wd;
			`TC_A_ZERO_RLD_LO: n.timer_zero_reload_low = wd;
			`TC_A_ZERO_RLD_HI: n.timer_zero_reload_high = wd;
			`TC_A_ONE_RLD_LO: n.timer_one_reload_low = wd;
			`TC_A_ONE_RLD_HI: n.timer_one_reload_high = wd;
			`TC_A_X_LO: n.tl2 = wd;
			`TC_A_X_HI: n.th2 = wd;
			`TC_A_X_CAP_LO: n.capl = wd;
			`TC_A_X_CAP_HI: n.caph = wd;
			`TC_A_MODE_SEL: n.timer_mode_select = wd;
			default: ;
			endcase
		end
		// hardware flag sets win over a clearing write
		if (ovf0 && !s.timer_output_enable_status[`TC_OE0])
			n.timer_run_overflow_control[`TC_RF0] = 1'b1;
		if ((ovf1 || ovf_hi0) && !s.timer_output_enable_status[`TC_OE1])
			n.timer_run_overflow_control[`TC_RF1] = 1'b1;
		if (ovf2 && !baud)
			n.xctl[`TC_XF] = 1'b1;
		if (ex2)
			n.xctl[`TC_XEXF] = 1'b1;
		// shared pins show toggle or port latch
		n.pin0 = s.timer_output_enable_status[`TC_OE0] ? n.tog0 : port_latch_zero;
		n.pin1 = s.timer_output_enable_status[`TC_OE1] ? n.tog1 : port_latch_one;
		// read returns the live value one cycle later, upper byte zero
		if (sfr_rd)
		begin
			n.rdata = 16'h0000;
			case (sfr_addr)
			`TC_A_RUN_CTRL: n.rdata[7:0] = s.timer_run_overflow_control;
			`TC_A_OUT_STAT: n.rdata[7:0] = s.timer_output_enable_status;
			`TC_A_X_CTRL: n.rdata[7:0] = s.xctl;
			`TC_A_X_MODE: n.rdata[7:0] = s.xmod;
			`TC_A_SYS_CFG: n.rdata[7:0] = s.system_configuration;
			`TC_A_ZERO_LO: n.rdata[7:0] = s.tl0;
			`TC_A_ZERO_HI: n.rdata[7:0] = s.th0;
			`TC_A_ONE_LO: n.rdata[7:0] = s.tl1;
			`TC_A_ONE_HI: n.rdata[7:0] = s.th1;
			`TC_A_ZERO_RLD_LO: n.rdata[7:0] = s.timer_zero_reload_low;
			`TC_A_ZERO_RLD_HI: n.rdata[7:0] = s.timer_zero_reload_high;
			`TC_A_ONE_RLD_LO: n.rdata[7:0] = s.timer_one_reload_low;
			`TC_A_ONE_RLD_HI: n.rdata[7:0] = s.timer_one_reload_high;
			`TC_A_X_LO: n.rdata[7:0] = s.tl2;
			`TC_A_X_HI: n.rdata[7:0] = s.th2;
			`TC_A_X_CAP_LO: n.rdata[7:0] = s.capl;
			`TC_A_X_CAP_HI: n.rdata[7:0] = s.caph;
			`TC_A_MODE_SEL: n.rdata[7:0] = s.timer_mode_select;
			default: ;
			endcase
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk)
	begin
		if (reset)
			s <= '0;
		else if (ce)
			s <= n;
	end

	// outputs straight from flip-flops
	assign sfr_rdata = s.rdata;
	assign timer_base_clock = s.tick;
	assign shared_pin_zero = s.pin0;
	assign shared_pin_one = s.pin1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_presc4;
		(s.tick && ce && s.system_configuration[`TC_SCR_PT] == 2'b00)
			##1 (ce && s.system_configuration[`TC_SCR_PT] == 2'b00) [*3] |=> s.tick;
	endproperty
	a_presc4: assert property (p_presc4) else $error("divide by 4 spacing wrong");

	property p_reserved;
		ce && s.system_configuration[`TC_SCR_PT] == 2'b11 |=> !s.tick;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code ticked");

	property p_counter_no_base;
		ce && s.timer_mode_select[`TC_MZ_CT] && !fall[0] && !sfr_wr
			&& m0 == OPM_FREE16 |=> $stable(cnt0);
	endproperty
	a_counter_no_base: assert property (p_counter_no_base) else $error("counter used base tick");

	property p_count_edge;
		ce && fall[0] && s.timer_mode_select[`TC_MZ_CT] && !s.timer_mode_select[`TC_MZ_GATE]
			&& s.timer_run_overflow_control[`TC_RUN0] && m0 == OPM_FREE16 && !sfr_wr
			|=> cnt0 == $past(cnt0) + 16'h0001;
	endproperty
	a_count_edge: assert property (p_count_edge) else $error("edge not counted");

	property p_reload16;
		ce && en0 && m0 == OPM_RELOAD16 && cnt0 == 16'hffff && !sfr_wr
			|=> cnt0 == $past(rld0) && (s.timer_run_overflow_control[`TC_RF0] || s.timer_output_enable_status[`TC_OE0]);
	endproperty
	a_reload16: assert property (p_reload16) else $error("mode 0 reload wrong");

	property p_reload8;
		ce && en0 && m0 == OPM_RELOAD8 && s.tl0 == 8'hff && !sfr_wr
			|=> s.tl0 == $past(s.timer_zero_reload_low) && $stable(s.th0);
	endproperty
	a_reload8: assert property (p_reload8) else $error("8-bit reload wrong");

	property p_toggle;
		ce && ovf0 && s.timer_output_enable_status[`TC_OE0] && !sfr_wr
			|=> shared_pin_zero == !$past(s.tog0);
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin did not toggle");

	property p_gate;
		ce && s.timer_mode_select[`TC_MZ_GATE] && !ext_irq_pin_zero && m0 != OPM_SPLIT8
			&& !sfr_wr |=> $stable(cnt0);
	endproperty
	a_gate: assert property (p_gate) else $error("gated timer counted");

	property p_wide_write;
		ce && sfr_wr && sfr_addr == `TC_A_ZERO_LO |=> s.tl0 == $past(wd);
	endproperty
	a_wide_write: assert property (p_wide_write) else $error("low byte not written");

	property p_read_live;
		ce && sfr_rd && sfr_addr == `TC_A_ZERO_LO
			|=> sfr_rdata == {8'h00, $past(s.tl0)};
	endproperty
	a_read_live: assert property (p_read_live) else $error("read not live count");

	property p_down;
		ce && en2 && down && cnt2 != cap2 && !sfr_wr && !ex2
			|=> cnt2 == $past(cnt2) - 16'h0001;
	endproperty
	a_down: assert property (p_down) else $error("down count wrong");

	c_reload16: cover property (ce && ovf0 && m0 == OPM_RELOAD16);
	c_split: cover property (ce && ovf_hi0);
	c_down_wrap: cover property (ce && ovf2 && down);
	c_capture: cover property (ce && ex2 && capm);
endmodule
`default_nettype wire

// file: tb/count_source.sv
// stand-in for the outside event sources on the three count pins
// assumes the bench clock; pins change only after falling edges
`timescale 1ns/1ps
`default_nettype none
module count_source (
	// clock
	input wire logic clk,
	// count pins, idle high
	output logic [2:0] pins
);
	initial pins = 3'h7;

	// each level is held two clock cycles, the shortest the sampler must see
	task automatic pulse(input int idx, input int n);
		repeat (n)
		begin
			pins[idx] = 1'b0;
			repeat (2) @(negedge clk);
			pins[idx] = 1'b1;
			repeat (2) @(negedge clk);
		end
	endtask
endmodule
`default_nettype wire

// file: tb/timer_counter_front_end_tb_top.sv
// self-checking bench of the timer/counter front end
// assumes the design, its package and register header under hdl/
`timescale 1ns/1ps
`default_nettype none
`include "tc_regs.svh"
module timer_counter_front_end_tb_top;
	import tc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [10:0] sfr_addr = 11'h000;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [15:0] sfr_wdata = 16'h0000;
	logic [15:0] sfr_rdata;
	logic [15:0] v;
	logic [2:0] cpins;
	logic irq0 = 1'b1;
	logic latch0 = 1'b1;
	logic base_clk;
	logic sh0;
	logic [31:0] seed = 32'd44500;
	logic [7:0] mdl [logic [10:0]];
	int miscompares = 0;
	int total_checks = 0;
	int n;
	logic [10:0] regs [18] = '{11'h410, 11'h411, 11'h418, 11'h419, 11'h440,
		11'h450, 11'h451, 11'h452, 11'h453, 11'h454, 11'h455, 11'h456,
		11'h457, 11'h458, 11'h459, 11'h45a, 11'h45b, 11'h45c};

	// 250 MHz clock
	always #2 clk = ~clk;

	timer_counter_front_end timer_counter_front_end_inst (
		.clk(clk), .reset(reset), .ce(ce),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.count_pin_zero(cpins[0]), .count_pin_one(cpins[1]),
		.count_pin_third(cpins[2]), .third_ext_pin(1'b1),
		.ext_irq_pin_zero(irq0), .ext_irq_pin_one(1'b1),
		.port_latch_zero(latch0), .port_latch_one(1'b0),
		.timer_base_clock(base_clk), .shared_pin_zero(sh0),
		.shared_pin_one()
	);

	count_source count_source_inst (.clk(clk), .pins(cpins));

	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	// bits a register keeps; the rest read back zero
	function automatic logic [7:0] mask(input logic [10:0] a);
		case (a)
			`TC_A_OUT_STAT: return `TC_OSTAT_MASK;
			`TC_A_X_MODE: return `TC_XMOD_MASK;
			`TC_A_SYS_CFG: return `TC_SCR_MASK;
			default: return 8'hff;
		endcase
	endfunction

	// passes when got equals lo or lies in (lo, hi]; unknown never passes
	task automatic chk(input string nm, input logic [15:0] lo,
		input logic [15:0] hi, input logic [15:0] got);
		total_checks++;
		if (got !== lo && (got > lo && got <= hi) !== 1'b1)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, lo, got);
		end
	endtask

	// one write cycle; model keeps the low byte under the register mask
	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
		mdl[a] = d[7:0] & mask(a);
	endtask

	// one read cycle; data is registered at the edge that takes it
	task automatic rd(input logic [10:0] a, output logic [15:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	// k falling edges on one pin, then the register at a is read back
	task automatic cnt(input int p, input int k, input logic [10:0] a,
		input logic [15:0] e);
		count_source_inst.pulse(p, k);
		repeat (6) @(negedge clk);
		rd(a, v);
		chk("count", e, e, v);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (12) @(negedge clk);
		reset = 1'b0;
		foreach (regs[i])
		begin
			rd(regs[i], v);
			chk("reset value", 16'h0, 16'h0, v);
		end
		wr(11'h412, 16'hffff);
		rd(11'h412, v);
		chk("unmapped", 16'h0, 16'h0, v);
		$display("test reset values done");
		// random wide writes store only the masked low byte
		repeat (2)
			foreach (regs[i])
				if (i != 0 && i != 2)
				begin
					wr(regs[i], xs());
					rd(regs[i], v);
					chk("reg", {8'h00, mdl[regs[i]]}, {8'h00, mdl[regs[i]]}, v);
				end
		$display("test register access done");
		// base tick rate for every prescale code
		for (int c = 0; c < 4; c++)
		begin
			wr(`TC_A_SYS_CFG, 16'(c << 2));
			n = 0;
			repeat (256)
			begin
				@(negedge clk);
				n += int'(base_clk === 1'b1);
			end
			chk("base ticks", (c == 3) ? 16'd0 : 16'((64 >> (2 * c)) - 1),
				(c == 3) ? 16'd0 : 16'(64 >> (2 * c)), 16'(n));
		end
		$display("test prescaler done");
		// timer mode at /16 read while running
		wr(`TC_A_SYS_CFG, 16'h0004);
		wr(`TC_A_MODE_SEL, 16'h0001);
		wr(`TC_A_ZERO_LO, 16'h0000);
		wr(`TC_A_ZERO_HI, 16'h0000);
		wr(`TC_A_RUN_CTRL, 16'h0010);
		// a frozen stretch must not add to the count
		ce = 1'b0;
		repeat (64) @(negedge clk);
		ce = 1'b1;
		repeat (160) @(negedge clk);
		rd(`TC_A_ZERO_LO, v);
		chk("live count", 16'd9, 16'd11, v);
		wr(`TC_A_RUN_CTRL, 16'h0000);
		$display("test timer mode done");
		// counter mode on each timer, gate closed then open on timer zero
		wr(`TC_A_MODE_SEL, 16'h000d);
		wr(`TC_A_ZERO_LO, 16'h0000);
		wr(`TC_A_RUN_CTRL, 16'h0010);
		irq0 = 1'b0;
		cnt(0, 3, `TC_A_ZERO_LO, 16'h0000);
		irq0 = 1'b1;
		cnt(0, 5, `TC_A_ZERO_LO, 16'h0005);
		wr(`TC_A_MODE_SEL, 16'h0050);
		// counts were left random by the register access test
		wr(`TC_A_ONE_LO, 16'h0000);
		wr(`TC_A_RUN_CTRL, 16'h0040);
		cnt(1, 7, `TC_A_ONE_LO, 16'h0007);
		wr(`TC_A_X_MODE, 16'h0000);
		wr(`TC_A_X_LO, 16'h0000);
		wr(`TC_A_X_CTRL, 16'h0006);
		cnt(2, 4, `TC_A_X_LO, 16'h0004);
		wr(`TC_A_X_CTRL, 16'h0000);
		$display("test counter mode done");
		// 16-bit reload, flag, toggle output
		wr(`TC_A_MODE_SEL, 16'h0004);
		wr(`TC_A_OUT_STAT, 16'h0000);
		wr(`TC_A_ZERO_RLD_LO, 16'h0034);
		wr(`TC_A_ZERO_RLD_HI, 16'h0012);
		wr(`TC_A_ZERO_LO, 16'h00fe);
		wr(`TC_A_ZERO_HI, 16'h00ff);
		wr(`TC_A_RUN_CTRL, 16'h0010);
		cnt(0, 3, `TC_A_ZERO_LO, 16'h0035);
		rd(`TC_A_ZERO_HI, v);
		chk("reload high", 16'h0012, 16'h0012, v);
		rd(`TC_A_RUN_CTRL, v);
		chk("flag set", 16'h0030, 16'h0030, v);
		chk("latch on pin", 16'h1, 16'h1, {15'h0, sh0});
		wr(`TC_A_RUN_CTRL, 16'h0010);
		wr(`TC_A_OUT_STAT, 16'h0001);
		repeat (2) @(negedge clk);
		chk("toggle on pin", 16'h1, 16'h1, {15'h0, sh0});
		wr(`TC_A_ZERO_LO, 16'h00ff);
		wr(`TC_A_ZERO_HI, 16'h00ff);
		cnt(0, 1, `TC_A_RUN_CTRL, 16'h0010);
		chk("toggle flipped", 16'h0, 16'h0, {15'h0, sh0});
		$display("test reload and toggle done");
		// 8-bit reload on timer one, then mode 3 holds
		wr(`TC_A_MODE_SEL, 16'h0060);
		wr(`TC_A_ONE_RLD_LO, 16'h0080);
		wr(`TC_A_ONE_LO, 16'h00ff);
		wr(`TC_A_ONE_HI, 16'h0055);
		wr(`TC_A_RUN_CTRL, 16'h0040);
		cnt(1, 1, `TC_A_ONE_LO, 16'h0080);
		rd(`TC_A_ONE_HI, v);
		chk("high kept", 16'h0055, 16'h0055, v);
		rd(`TC_A_RUN_CTRL, v);
		chk("flag one", 16'h00c0, 16'h00c0, v);
		wr(`TC_A_MODE_SEL, 16'h0070);
		cnt(1, 2, `TC_A_ONE_LO, 16'h0080);
		$display("test modes done");
		conclude();
	end
endmodule
`default_nettype wire
